// ==== core/art_top.sv ====
// autoreload timer with one waveform output
//
// Added by the designer: the strobed register port.
module art_top
    import art_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // slow timebase pulse, one cycle per slow tick
    input wire logic slow_tick_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // pin function
    output logic wave_o,
    output logic wave_oe_o,
    // interrupt
    output logic irq_o
);
    import art_pkg::*;

    logic [11:0] cnt_reg; // upcounter
    logic [11:0] reload_reg; // reload value
    logic [11:0] duty_reg; // duty value as written
    logic [11:0] shadow_reg; // duty copy taken at overflow
    logic [1:0] cksel_reg; // clock select
    logic wrap_reg; // wrap flag
    logic wrap_ie_reg; // wrap interrupt enable
    logic match_ie_reg; // match interrupt enable
    logic match_reg; // match flag
    logic pol_reg; // polarity
    logic oe_reg; // output enable
    logic lock_reg; // compare suspended
    logic wave_reg; // raw waveform before polarity
    logic [11:0] cnt_next; // counter after this edge
    logic wr_tcs; // write of timer status
    logic wr_wcs; // write of waveform status
    logic wr_opc; // write of pin control
    logic wr_rld_hi; // write of reload high byte
    logic wr_rld_lo; // write of reload low byte
    logic wr_duty_hi; // write of duty high byte
    logic wr_duty_lo; // write of duty low byte
    logic tick; // counter advance
    logic ovf; // overflow this tick
    logic [11:0] cmp_val; // value compared
    logic hit; // compare hit
    logic rd_tcs; // read of timer status
    logic rd_wcs; // read of waveform status
    logic [7:0] rdata_next; // read mux

    // clock selection
    art_tick u_tick (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .cksel_i(cksel_reg),
        .slow_tick_i(slow_tick_i),
        .tick_o(tick)
    );

    // overflow when counter at top and advancing
    assign ovf = tick && (cnt_reg == ART_CNT_MAX);

    // counter value once this edge has passed
    always_comb begin
        cnt_next = cnt_reg;
        if (ovf) begin
            // top reached: restart from the reload value
            cnt_next = reload_reg;
        end else if (tick) begin
            // plain step up
            cnt_next = cnt_reg + 12'h001;
        end
    end

    // compare value that the counter meets once this edge has passed
    always_comb begin
        cmp_val = duty_reg;
        if (oe_reg) begin
            // waveform uses shadow
            // the shadow takes the duty value at this same overflow edge
            cmp_val = ovf ? duty_reg : shadow_reg;
        end else begin
            cmp_val = duty_reg;
        end
    end

    // hit marks the edge where the counter reaches the compare value,
    // so a duty equal to the reload value gives no high time at all
    // compare suspended; zero duty never compares
    assign hit = tick && !lock_reg && (cmp_val != ART_RST_WORD) && (cnt_next == cmp_val);

    // register strobe decode; the clock enable gates them downstream
    assign rd_tcs = rd_i && (addr_i == ART_OFS_TCS);
    assign rd_wcs = rd_i && (addr_i == ART_OFS_WCS);
    assign wr_tcs = wr_i && (addr_i == ART_OFS_TCS);
    assign wr_wcs = wr_i && (addr_i == ART_OFS_WCS);
    assign wr_opc = wr_i && (addr_i == ART_OFS_OPC);
    assign wr_rld_hi = wr_i && (addr_i == ART_OFS_RLD_HI);
    assign wr_rld_lo = wr_i && (addr_i == ART_OFS_RLD_LO);
    assign wr_duty_hi = wr_i && (addr_i == ART_OFS_DUTY_HI);
    assign wr_duty_lo = wr_i && (addr_i == ART_OFS_DUTY_LO);

    // counter
    // tick already carries the clock select, so only ovf and tick matter
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_reg <= ART_RST_WORD;
        end else if (clk_en_i) begin
            if (ovf) begin
                cnt_reg <= reload_reg;
            end else if (tick) begin
                cnt_reg <= cnt_reg + 12'h001;
            end
        end
    end

    // reload value, written bytewise
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            reload_reg <= ART_RST_WORD;
        end else if (clk_en_i) begin
            // reserved upper bits dropped; software keeps them zero anyway
            if (wr_rld_hi) begin
                // high byte fills bits 11:8
                reload_reg[11:8] <= wdata_i[3:0];
            end else if (wr_rld_lo) begin
                // low byte fills bits 7:0
                reload_reg[7:0] <= wdata_i;
            end
        end
    end

    // duty value and compare lock
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            duty_reg <= ART_RST_WORD;
            lock_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_duty_hi) begin
                // high byte also suspends the compare
                duty_reg[11:8] <= wdata_i[3:0];
                lock_reg <= 1'b1;
            end else if (wr_duty_lo) begin
                // low byte completes the value and releases the compare
                duty_reg[7:0] <= wdata_i;
                lock_reg <= 1'b0;
            end
        end
    end

    // shadow copy, even mid-update
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            shadow_reg <= ART_RST_WORD;
        end else if (clk_en_i && ovf) begin
            // transfer at overflow
            // mid-update this holds the new high and the old low bits
            shadow_reg <= duty_reg;
        end
    end

    // timer control: clock select and interrupt enables
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cksel_reg <= 2'h0;
            wrap_ie_reg <= 1'b0;
            match_ie_reg <= 1'b0;
        end else if (clk_en_i && wr_tcs) begin
            // wrap flag bit is read-only, a write leaves it alone
            cksel_reg <= wdata_i[ART_TCS_CKS_HI:ART_TCS_CKS_LO];
            wrap_ie_reg <= wdata_i[ART_TCS_WRAP_IE];
            match_ie_reg <= wdata_i[ART_TCS_MATCH_IE];
        end
    end

    // output polarity
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pol_reg <= 1'b0;
        end else if (clk_en_i && wr_wcs) begin
            // polarity is software read/write
            // match flag bit ignores writes, only a read clears it
            pol_reg <= wdata_i[ART_WCS_POL];
        end
    end

    // output enable, hands the pin to the waveform
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            oe_reg <= 1'b0;
        end else if (clk_en_i && wr_opc) begin
            // reserved bits 7:1 dropped
            oe_reg <= wdata_i[ART_OPC_OE];
        end
    end

    // wrap flag, set beats read clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wrap_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (ovf) begin
                // an overflow in the reading cycle is kept for the next read
                wrap_reg <= 1'b1;
            end else if (rd_tcs) begin
                wrap_reg <= 1'b0;
            end
        end
    end

    // match flag, set beats read clear
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            match_reg <= 1'b0;
        end else if (clk_en_i) begin
            if (hit) begin
                // a hit in the reading cycle is kept for the next read
                match_reg <= 1'b1;
            end else if (rd_wcs) begin
                match_reg <= 1'b0;
            end
        end
    end

    // raw waveform: high at overflow, low at match
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wave_reg <= 1'b0;
        end else if (clk_en_i) begin
            // set on overflow, clear on match
            if (hit && oe_reg) begin
                // match wins so a duty equal to the reload stays low
                wave_reg <= 1'b0;
            end else if (ovf) begin
                // period starts at the reload value
                wave_reg <= 1'b1;
            end
        end
    end

    // pin outputs; one cycle behind raw waveform
    // enable low forces the level low rather than floating it
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            wave_o <= 1'b0;
            wave_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            wave_o <= oe_reg & (wave_reg ^ pol_reg);
            wave_oe_o <= oe_reg;
        end
    end

    // interrupt level from flags and enables
    // one cycle behind the flags, like every other output
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_o <= (wrap_reg & wrap_ie_reg) | (match_reg & match_ie_reg);
        end
    end

    // read mux, unmapped reads zero
    // reserved bits read as zero in every register
    always_comb begin
        rdata_next = ART_RST_BYTE;
        case (addr_i)
            ART_OFS_TCS: rdata_next = {3'b000, cksel_reg, wrap_reg, wrap_ie_reg, match_ie_reg};
            ART_OFS_CNT_HI: rdata_next = {4'h0, cnt_reg[11:8]};
            ART_OFS_CNT_LO: rdata_next = cnt_reg[7:0];
            ART_OFS_RLD_HI: rdata_next = {4'h0, reload_reg[11:8]};
            ART_OFS_RLD_LO: rdata_next = reload_reg[7:0];
            ART_OFS_OPC: rdata_next = {7'h00, oe_reg};
            ART_OFS_WCS: rdata_next = {6'h00, pol_reg, match_reg};
            ART_OFS_DUTY_HI: rdata_next = {4'h0, duty_reg[11:8]};
            ART_OFS_DUTY_LO: rdata_next = duty_reg[7:0];
            default: rdata_next = ART_RST_BYTE;
        endcase
    end

    // read data one cycle after strobe, zero otherwise
    // zero between reads so a stale value never looks like an answer
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rdata_o <= ART_RST_BYTE;
        end else if (clk_en_i) begin
            rdata_o <= rd_i ? rdata_next : ART_RST_BYTE;
        end
    end
endmodule

// ==== core/art_pkg.sv ====
// Functional notes
// - overflow reloads counter from reload value
// - reload value sets waveform period
// - waveform mode: duty sets duty cycle
// - compare mode: duty compared with counter
// - polarity bit inverts waveform output
// - match flag set on counter equal duty
// - reading waveform status clears match flag
// - output enable selects pin function
// - all registers reset to zero
// - overflow loads shadow, output high; match low
// - clock select: off, slow, cpu, reserved
// - wrap flag on FFFh wrap, read clears
// - compare suspended between high and low writes
package art_pkg;
    // register byte offsets
    localparam logic [7:0] ART_OFS_TCS = 8'h0d;
    localparam logic [7:0] ART_OFS_CNT_HI = 8'h0e;
    localparam logic [7:0] ART_OFS_CNT_LO = 8'h0f;
    localparam logic [7:0] ART_OFS_RLD_HI = 8'h10;
    localparam logic [7:0] ART_OFS_RLD_LO = 8'h11;
    localparam logic [7:0] ART_OFS_OPC = 8'h12;
    localparam logic [7:0] ART_OFS_WCS = 8'h13;
    localparam logic [7:0] ART_OFS_DUTY_HI = 8'h17;
    localparam logic [7:0] ART_OFS_DUTY_LO = 8'h18;
    // timer control/status field positions
    localparam int ART_TCS_CKS_HI = 4;
    localparam int ART_TCS_CKS_LO = 3;
    localparam int ART_TCS_WRAP = 2;
    localparam int ART_TCS_WRAP_IE = 1;
    localparam int ART_TCS_MATCH_IE = 0;
    // waveform status field positions
    localparam int ART_WCS_POL = 1;
    localparam int ART_WCS_MATCH = 0;
    // output control field
    localparam int ART_OPC_OE = 0;
    // reset values and limits
    localparam logic [7:0] ART_RST_BYTE = 8'h00;
    localparam logic [11:0] ART_RST_WORD = 12'h000;
    localparam logic [11:0] ART_CNT_MAX = 12'hfff;
    // clock select codes
    typedef enum logic [1:0] {
        ART_CK_OFF = 2'b00,
        ART_CK_SLOW = 2'b01,
        ART_CK_CPU = 2'b10,
        ART_CK_RSVD = 2'b11
    } art_cksel_type;
endpackage

// ==== core/art_tick.sv ====
// picks the counter advance pulse from the clock select
module art_tick
    import art_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // selection
    input wire logic [1:0] cksel_i,
    input wire logic slow_tick_i,
    // advance pulse
    output logic tick_o
);
    // registered so the counter sees a clean one-cycle step
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            tick_o <= 1'b0;
        end else if (clk_en_i) begin
            case (art_cksel_type'(cksel_i))
                ART_CK_OFF: tick_o <= 1'b0;
                ART_CK_SLOW: tick_o <= slow_tick_i;
                ART_CK_CPU: tick_o <= 1'b1;
                ART_CK_RSVD: tick_o <= 1'b0; // reserved code holds the counter
                default: tick_o <= 1'b0;
            endcase
        end
    end
endmodule

// ==== tb/art_asserts.sv ====
// watches the timer ports only
module art_chk
    import art_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // pin and interrupt
    input wire logic wave_o,
    input wire logic wave_oe_o,
    input wire logic irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    pin_gate_a: assert property (!wave_oe_o |-> !wave_o)
        else $error("wave driven while pin released");
    reset_zero_a: assert property ($rose(rstn_i) |-> !rdata_o && !wave_oe_o && !irq_o)
        else $error("outputs not zero after reset");
    idle_zero_a: assert property (clk_en_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
    wcs_rsvd_a: assert property (rd_i && addr_i == ART_OFS_WCS |=> !rdata_o[7:2])
        else $error("waveform status reserved bits set");
    tcs_rsvd_a: assert property (rd_i && addr_i == ART_OFS_TCS |=> !rdata_o[7:5])
        else $error("timer status reserved bits set");
    cnt_rsvd_a: assert property (rd_i && addr_i == ART_OFS_CNT_HI |=> !rdata_o[7:4])
        else $error("counter high above twelve bits");
    oe_follow_a: assert property (wr_i && addr_i == ART_OFS_OPC |=> ##1
        wave_oe_o == $past(wdata_i[0], 2))
        else $error("pin enable not following write");
    irq_cause_a: assert property (rd_i && addr_i == ART_OFS_TCS ##1
        rdata_o[2] && rdata_o[1] |-> irq_o)
        else $error("enabled wrap without interrupt");
    // main scenarios reached
    irq_seen_c: cover property ($rose(irq_o));
    wave_seen_c: cover property (wave_oe_o && wave_o);
    match_seen_c: cover property (rd_i && addr_i == ART_OFS_WCS ##1 rdata_o[0]);
endmodule
bind art_top art_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .wave_o(wave_o), .wave_oe_o(wave_oe_o), .irq_o(irq_o));

// ==== tb/tb_top.sv ====
// register level bench for the reload timer
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import art_pkg::*;
    logic core_clk_i = 1'b0, rstn_i = 1'b0, slow_tick_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
    logic wave_o, wave_oe_o, irq_o;
    int err_total = 0, checked = 0;
    // every register plus one unmapped hole
    logic [7:0] ofs [10] = '{ART_OFS_TCS, ART_OFS_CNT_HI, ART_OFS_CNT_LO, ART_OFS_RLD_HI,
        ART_OFS_RLD_LO, ART_OFS_OPC, ART_OFS_WCS, ART_OFS_DUTY_HI, ART_OFS_DUTY_LO, 8'h14};
    always #12.5 core_clk_i = ~core_clk_i;
    art_top uut (.core_clk_i, .rstn_i, .clk_en_i, .slow_tick_i, .addr_i, .wdata_i,
        .wr_i, .rd_i, .rdata_o, .wave_o, .wave_oe_o, .irq_o);
    task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // one cycle write strobe
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(logic [7:0] a, logic [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1;
        cmp($sformatf("reg %h", a), e, rdata_o);
    endtask
    // returns just past an edge so outputs are settled when sampled
    task automatic cyc(int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // two whole periods, so the phase does not matter
    task automatic hcnt(logic [7:0] e);
        logic [7:0] h;
        h = 8'h00;
        repeat (32) begin
            @(posedge core_clk_i);
            #1;
            h += wave_o;
        end
        cmp("wave high count", e, h);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d checks %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        foreach (ofs[i]) rchk(ofs[i], 8'h00);
        // slow timebase: five pulses give five counts
        wr(ART_OFS_TCS, 8'h08);
        repeat (5) begin
            @(posedge core_clk_i);
            slow_tick_i <= 1'b1;
            @(posedge core_clk_i);
            slow_tick_i <= 1'b0;
        end
        cyc(3);
        wr(ART_OFS_TCS, 8'h00);
        rchk(ART_OFS_CNT_LO, 8'h05);
        // reload ff0, duty high only: compare stays locked
        wr(ART_OFS_RLD_HI, 8'h0f);
        wr(ART_OFS_RLD_LO, 8'hf0);
        wr(ART_OFS_DUTY_HI, 8'h0f);
        wr(ART_OFS_TCS, 8'h10);
        cyc(4200);
        wr(ART_OFS_TCS, 8'h00);
        rchk(ART_OFS_WCS, 8'h00);
        rchk(ART_OFS_CNT_HI, 8'h0f);
        rchk(ART_OFS_RLD_LO, 8'hf0);
        rchk(ART_OFS_TCS, 8'h04);
        rchk(ART_OFS_TCS, 8'h00);
        // clock enable low: a reload write must be ignored
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        wr(ART_OFS_RLD_LO, 8'h00);
        clk_en_i <= 1'b1;
        rchk(ART_OFS_RLD_LO, 8'hf0);
        // compare mode at ff8 with both interrupts on
        wr(ART_OFS_DUTY_LO, 8'hf8);
        wr(ART_OFS_TCS, 8'h13);
        cyc(40);
        cmp("irq", 8'h01, {7'h00, irq_o});
        wr(ART_OFS_TCS, 8'h03);
        rchk(ART_OFS_WCS, 8'h01);
        rchk(ART_OFS_WCS, 8'h00);
        rchk(ART_OFS_TCS, 8'h07);
        rchk(ART_OFS_TCS, 8'h03);
        cyc(3);
        cmp("irq", 8'h00, {7'h00, irq_o});
        // flags set but masked
        wr(ART_OFS_TCS, 8'h10);
        cyc(40);
        cmp("irq", 8'h00, {7'h00, irq_o});
        // waveform: reload ff0, duty ff4 gives 4 of 16 high
        wr(ART_OFS_DUTY_HI, 8'h0f);
        wr(ART_OFS_DUTY_LO, 8'hf4);
        wr(ART_OFS_OPC, 8'h01);
        cyc(40);
        cmp("wave oe", 8'h01, {7'h00, wave_oe_o});
        hcnt(8'h08);
        wr(ART_OFS_WCS, 8'h02);
        cyc(4);
        hcnt(8'h18);
        wr(ART_OFS_OPC, 8'h00);
        cyc(4);
        cmp("wave oe", 8'h00, {7'h00, wave_oe_o});
        hcnt(8'h00);
        tally_and_finish();
    end
endmodule
